// File: rtl/mmt_core.sv
// Module management timing: start-up, reset filter, flags, masks, interrupt, power and select.
// Overview of operation
// - After power-on or hot plug the module is fully functional within 2000 ms.
// - Reset pin low for at least 2 us is a reset; shorter lows ignored.
// - Bus answering starts no later than 2000 ms after power-on.
// - Within 2000 ms clear data-not-ready and pull interrupt low.
// - Fully functional only once interrupt asserts for cleared data-not-ready.
// - After reset pin rises, fully functional within 2000 ms.
// - Low-power pin high drops power level within 100 us.
// - Any interrupt condition pulls interrupt output low within 200 ms.
// - Host read clears flags; interrupt releases within 500 us of last clear.
// - Receive loss-of-signal sets its flag and interrupt within 100 ms.
// - Transmitter fault sets its flag and interrupt within 200 ms.
// - Other conditions set their flag and interrupt within 200 ms.
// - A set mask bit stops its flag driving interrupt within 100 ms.
// - A cleared mask bit restores interrupt for that flag within 100 ms.
// - Select asserted makes the module answer the bus within 100 us.
// - Select released stops bus answering within 100 us.
// - Power-down bit set enters low power within 100 ms.
// - Power-down bit cleared returns to full function within 300 ms.
// - Mask and power-down writes take effect from the write's end.
`timescale 1ns/1ps
module mmt_core
#(
    parameter int FLAG_W = mmt_pkg::FLAG_W_DEF,
    parameter int INIT_CYCLES = mmt_pkg::INIT_CYC
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic module_reset_n_in,
    input wire logic low_power_request_in,
    input wire logic module_select_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic rx_los_in,
    input wire logic tx_fault_in,
    input wire logic [FLAG_W-3:0] other_cond_in,
    input wire logic flag_read_in,
    input wire logic mask_wr_in,
    input wire logic [FLAG_W-1:0] mask_wr_data_in,
    input wire logic pdown_wr_in,
    input wire logic pdown_wr_data_in,
    output logic interrupt_out_n,
    output logic data_not_ready_out,
    output logic [FLAG_W-1:0] flag_out,
    output logic [FLAG_W-1:0] mask_out,
    output logic low_power_out,
    output logic bus_respond_out,
    output logic ready_out
);

    localparam int LAT_MAX = 4;

    // ****************************************************************
    // Bus monitor
    // ****************************************************************
    mmt_twi_if twi();

    mmt_twi_mon u_mon
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .twi(twi)
    );

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_q, rst_sync_d;
    logic [1:0] lp_sync_q, lp_sync_d;
    logic [1:0] sel_sync_q, sel_sync_d;
    logic [FLAG_W-1:0] cond_s0_q, cond_s0_d;
    logic [FLAG_W-1:0] cond_s1_q, cond_s1_d;
    logic [FLAG_W-1:0] cond_prev_q, cond_prev_d;
    logic mrst_s;
    logic lp_s;
    logic sel_s;
    logic [FLAG_W-1:0] cond_rise;

    // Two stages per pin; only the second stage is read by logic.
    always_comb
    begin
        rst_sync_d = {rst_sync_q[0], module_reset_n_in};
        lp_sync_d = {lp_sync_q[0], low_power_request_in};
        sel_sync_d = {sel_sync_q[0], module_select_n_in};
        cond_s0_d = {other_cond_in, tx_fault_in, rx_los_in};
        cond_s1_d = cond_s0_q;
        cond_prev_d = cond_s1_q;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            rst_sync_q <= {2{mmt_pkg::RST_SYNC_IDLE}};
            lp_sync_q <= 2'h0;
            sel_sync_q <= {2{mmt_pkg::SEL_SYNC_IDLE}};
            cond_s0_q <= '0;
            cond_s1_q <= '0;
            cond_prev_q <= '0;
        end
        else
        begin
            rst_sync_q <= rst_sync_d;
            lp_sync_q <= lp_sync_d;
            sel_sync_q <= sel_sync_d;
            cond_s0_q <= cond_s0_d;
            cond_s1_q <= cond_s1_d;
            cond_prev_q <= cond_prev_d;
        end
    end

    assign mrst_s = rst_sync_q[1];
    assign lp_s = lp_sync_q[1];
    assign sel_s = ~sel_sync_q[1];
    // Flags latch on the assertion of a condition, one cycle after it is seen.
    assign cond_rise = cond_s1_q & ~cond_prev_q;

    // ****************************************************************
    // Reset filter and start-up sequencer
    // ****************************************************************
    mmt_pkg::mmt_state_t state_q, state_d;
    logic [mmt_pkg::RST_CNT_W-1:0] low_cnt_q, low_cnt_d;
    logic [mmt_pkg::INIT_CNT_W-1:0] init_cnt_q, init_cnt_d;
    logic mrst_prev_q, mrst_prev_d;
    logic init_done;

    // A glitch shorter than the minimum pulse never reaches the sequencer.
    assign init_done = (state_q == mmt_pkg::ST_INIT)
        && (init_cnt_q == mmt_pkg::INIT_CNT_W'(INIT_CYCLES - 1));

    always_comb
    begin
        state_d = state_q;
        init_cnt_d = init_cnt_q;
        mrst_prev_d = mrst_s;
        low_cnt_d = '0;
        if (!mrst_s && (low_cnt_q != mmt_pkg::RST_CNT_W'(mmt_pkg::RST_MIN_CYC)))
        begin
            low_cnt_d = low_cnt_q + 1'b1;
        end
        else if (!mrst_s)
        begin
            low_cnt_d = low_cnt_q;
        end
        case (state_q)
            mmt_pkg::ST_HOLD:
            begin
                init_cnt_d = '0;
                if (mmt_pkg::rise_f(mrst_prev_q, mrst_s) || mrst_s)
                begin
                    state_d = mmt_pkg::ST_INIT;
                end
            end
            mmt_pkg::ST_INIT:
            begin
                init_cnt_d = init_cnt_q + 1'b1;
                if (init_done)
                begin
                    state_d = mmt_pkg::ST_READY;
                end
            end
            mmt_pkg::ST_READY:
            begin
                init_cnt_d = '0;
            end
            default:
            begin
                state_d = mmt_pkg::ST_HOLD;
            end
        endcase
        // A low held for the minimum time restarts the whole sequence.
        if (!mrst_s && (low_cnt_q == mmt_pkg::RST_CNT_W'(mmt_pkg::RST_MIN_CYC - 1)))
        begin
            state_d = mmt_pkg::ST_HOLD;
        end
        if ((state_q == mmt_pkg::ST_HOLD) && !mrst_s)
        begin
            state_d = mmt_pkg::ST_HOLD;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= mmt_pkg::ST_INIT;
            low_cnt_q <= '0;
            init_cnt_q <= '0;
            mrst_prev_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            low_cnt_q <= low_cnt_d;
            init_cnt_q <= init_cnt_d;
            mrst_prev_q <= mrst_prev_d;
        end
    end

    // ****************************************************************
    // Pending host writes, flags, masks and outputs
    // ****************************************************************
    logic [FLAG_W-1:0] flags_q, flags_d;
    logic [FLAG_W-1:0] mask_q, mask_d;
    logic [FLAG_W-1:0] mask_pend_q, mask_pend_d;
    logic mask_pv_q, mask_pv_d;
    logic pd_pend_q, pd_pend_d;
    logic pd_pv_q, pd_pv_d;
    logic rd_pend_q, rd_pend_d;
    logic pdown_q, pdown_d;
    logic dnr_q, dnr_d;
    logic init_flag_q, init_flag_d;
    logic int_n_q, int_n_d;
    logic lp_out_q, lp_out_d;
    logic resp_q, resp_d;
    logic rdy_q, rdy_d;
    logic commit;
    logic ready;

    // A stop only commits while no new frame has opened behind it.
    assign commit = twi.stop_pulse & ~twi.busy;
    assign ready = (state_q == mmt_pkg::ST_READY);

    // Writes wait for the end of their transaction; a new event always beats a read clear.
    always_comb
    begin
        mask_pend_d = mask_wr_in ? mask_wr_data_in : mask_pend_q;
        // A request that lands on the commit cycle is kept for the next stop.
        mask_pv_d = (mask_pv_q & ~commit) | mask_wr_in;
        pd_pend_d = pdown_wr_in ? pdown_wr_data_in : pd_pend_q;
        pd_pv_d = (pd_pv_q & ~commit) | pdown_wr_in;
        rd_pend_d = (rd_pend_q & ~commit) | flag_read_in;
        mask_d = (commit && mask_pv_q) ? mask_pend_q : mask_q;
        pdown_d = (commit && pd_pv_q) ? pd_pend_q : pdown_q;
        flags_d = flags_q;
        init_flag_d = init_flag_q;
        if (commit && rd_pend_q)
        begin
            flags_d = '0;
            init_flag_d = 1'b0;
        end
        flags_d = flags_d | (ready ? cond_rise : '0);
        dnr_d = ~ready;
        rdy_d = ready;
        if (init_done)
        begin
            init_flag_d = 1'b1;
        end
        if (!ready)
        begin
            flags_d = '0;
        end
        // Unmasked flags and the start-up event drive the interrupt.
        int_n_d = ~(init_flag_q | (|(flags_q & ~mask_q)));
        lp_out_d = lp_s | pdown_q;
        resp_d = ready & sel_s;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            flags_q <= '0;
            mask_q <= '0;
            mask_pend_q <= '0;
            mask_pv_q <= 1'b0;
            pd_pend_q <= 1'b0;
            pd_pv_q <= 1'b0;
            rd_pend_q <= 1'b0;
            pdown_q <= 1'b0;
            dnr_q <= 1'b1;
            rdy_q <= 1'b0;
            init_flag_q <= 1'b0;
            int_n_q <= 1'b1;
            lp_out_q <= 1'b0;
            resp_q <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            mask_pend_q <= mask_pend_d;
            mask_pv_q <= mask_pv_d;
            pd_pend_q <= pd_pend_d;
            pd_pv_q <= pd_pv_d;
            rd_pend_q <= rd_pend_d;
            pdown_q <= pdown_d;
            dnr_q <= dnr_d;
            rdy_q <= rdy_d;
            init_flag_q <= init_flag_d;
            int_n_q <= int_n_d;
            lp_out_q <= lp_out_d;
            resp_q <= resp_d;
        end
    end

    assign interrupt_out_n = int_n_q;
    assign data_not_ready_out = dnr_q;
    assign flag_out = flags_q;
    assign mask_out = mask_q;
    assign low_power_out = lp_out_q;
    assign bus_respond_out = resp_q;
    assign ready_out = rdy_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_init_end;
        init_done;
    endsequence

    sequence s_int_up;
        !init_flag_q ##0 1'b1;
    endsequence

    property p_init_ready;
        @(posedge clk_in) disable iff (sys_rst_in)
        (s_init_end and (mrst_s && (low_cnt_q == '0))) |=> ready ##1 !dnr_q;
    endproperty
    a_init_ready: assert property (p_init_ready) else $error("Sequencer missed the end of start-up.");

    property p_reset_accept;
        @(posedge clk_in) disable iff (sys_rst_in)
        !mrst_s && (low_cnt_q == mmt_pkg::RST_CNT_W'(mmt_pkg::RST_MIN_CYC - 1)) |=> (state_q == mmt_pkg::ST_HOLD);
    endproperty
    a_reset_accept: assert property (p_reset_accept) else $error("Long reset low was not taken.");

    property p_short_low;
        @(posedge clk_in) disable iff (sys_rst_in)
        ready && !mrst_s && (low_cnt_q != mmt_pkg::RST_CNT_W'(mmt_pkg::RST_MIN_CYC - 1)) |=> ready;
    endproperty
    a_short_low: assert property (p_short_low) else $error("Short reset glitch disturbed the module.");

    property p_startup_int;
        @(posedge clk_in) disable iff (sys_rst_in)
        (s_init_end and (mrst_s && (low_cnt_q == '0))) |=> init_flag_q ##1 !interrupt_out_n && !data_not_ready_out;
    endproperty
    a_startup_int: assert property (p_startup_int) else $error("Start-up did not raise the interrupt.");

    property p_bus_on;
        @(posedge clk_in) disable iff (sys_rst_in)
        $fell(module_select_n_in) ##1 (!module_select_n_in && ready) [*3] |=> bus_respond_out;
    endproperty
    a_bus_on: assert property (p_bus_on) else $error("Selected module did not answer.");

    property p_bus_off;
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(module_select_n_in) ##1 module_select_n_in [*3] |=> !bus_respond_out;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("Deselected module kept answering.");

    property p_lp_on;
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(low_power_request_in) ##1 low_power_request_in [*3] |=> low_power_out;
    endproperty
    a_lp_on: assert property (p_lp_on) else $error("Low-power request not obeyed.");

    property p_flag_int;
        @(posedge clk_in) disable iff (sys_rst_in)
        ready && (|(cond_rise & ~mask_q)) && !(commit && mask_pv_q) |=> (|flags_q) ##1 !interrupt_out_n;
    endproperty
    a_flag_int: assert property (p_flag_int) else $error("Unmasked flag did not pull the interrupt.");

    property p_read_release;
        @(posedge clk_in) disable iff (sys_rst_in)
        ready && commit && rd_pend_q ##1 (cond_rise == '0) && ready |=> s_int_up ##[1:LAT_MAX] interrupt_out_n;
    endproperty
    a_read_release: assert property (p_read_release) else $error("Interrupt not released after flag read.");

    property p_mask_commit;
        @(posedge clk_in) disable iff (sys_rst_in)
        commit && mask_pv_q |=> (mask_q == $past(mask_pend_q));
    endproperty
    a_mask_commit: assert property (p_mask_commit) else $error("Mask write not applied at end of write.");

    property p_mask_gate;
        @(posedge clk_in) disable iff (sys_rst_in)
        ((flags_q & ~mask_q) == '0) && !init_flag_q |=> interrupt_out_n;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("Masked flag still drives the interrupt.");

    property p_pdown;
        @(posedge clk_in) disable iff (sys_rst_in)
        commit && pd_pv_q |=> (pdown_q == $past(pd_pend_q)) ##1 (low_power_out == (pdown_q | $past(lp_s)));
    endproperty
    a_pdown: assert property (p_pdown) else $error("Power-down write not applied.");

endmodule

// File: rtl/mmt_pkg.sv
// Shared constants, timing figures and helper functions of the module management timing block.
package mmt_pkg;

    // ****************************************************************
    // Clock and timing figures
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_INIT_MS = 2000;
    localparam int T_RESET_MIN_US = 2;
    localparam int T_LP_ON_US = 100;
    localparam int T_INT_ON_MS = 200;
    localparam int T_INT_OFF_US = 500;
    localparam int T_LOS_MS = 100;
    localparam int T_MASK_MS = 100;
    localparam int T_SEL_US = 100;
    localparam int T_PDOWN_ON_MS = 100;
    localparam int T_PDOWN_OFF_MS = 300;

    // Initialisation wait is a longest time, so it rounds down.
    localparam longint INIT_CYC_L = (longint'(T_INIT_MS) * 64'd1000000) / CLK_PERIOD_NS;
    localparam int INIT_CYC = int'(INIT_CYC_L);
    // Reset pulse is a least time, so it rounds up.
    localparam int RST_MIN_CYC = (T_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Widths, field positions and reset values
    // ****************************************************************
    localparam int RST_CNT_W = 8;
    localparam int INIT_CNT_W = 32;
    localparam int FLAG_W_DEF = 8;
    localparam int FLAG_LOS_BIT = 0;
    localparam int FLAG_TXF_BIT = 1;
    localparam int FLAG_OTHER_LSB = 2;
    localparam logic RST_SYNC_IDLE = 1'b1;
    localparam logic SEL_SYNC_IDLE = 1'b1;

    // Main sequencer states.
    typedef enum logic [1:0]
    {
        ST_HOLD = 2'b00,
        ST_INIT = 2'b01,
        ST_READY = 2'b10
    } mmt_state_t;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Single-bit rising edge between a previous and a current sample.
    function automatic logic rise_f(input logic prev, input logic cur);
        rise_f = cur & ~prev;
    endfunction

    // Single-bit falling edge between a previous and a current sample.
    function automatic logic fall_f(input logic prev, input logic cur);
        fall_f = prev & ~cur;
    endfunction

endpackage

// File: rtl/mmt_twi_if.sv
// Carrier between the two-wire bus monitor and the management sequencer.
`timescale 1ns/1ps
interface mmt_twi_if;
    logic stop_pulse;
    logic busy;

    modport mon
    (
        output stop_pulse,
        output busy
    );

    modport core
    (
        input stop_pulse,
        input busy
    );
endinterface

// File: rtl/mmt_twi_mon.sv
// Two-wire bus line monitor: finds start and stop conditions on the sampled pins.
`timescale 1ns/1ps
module mmt_twi_mon
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    mmt_twi_if.mon twi
);

    // ****************************************************************
    // Pin synchronisers and edge history
    // ****************************************************************
    logic [1:0] scl_sync_q, scl_sync_d;
    logic [1:0] sda_sync_q, sda_sync_d;
    logic sda_prev_q, sda_prev_d;
    logic busy_q, busy_d;
    logic stop_q, stop_d;
    logic start_w;
    logic stop_w;

    // Stage zero feeds stage one only; the logic below reads stage one.
    always_comb
    begin
        scl_sync_d = {scl_sync_q[0], scl_in};
        sda_sync_d = {sda_sync_q[0], sda_in};
        sda_prev_d = sda_sync_q[1];
    end

    // Start is data falling while the clock is high, stop is data rising.
    assign start_w = scl_sync_q[1] & mmt_pkg::fall_f(sda_prev_q, sda_sync_q[1]);
    assign stop_w = scl_sync_q[1] & mmt_pkg::rise_f(sda_prev_q, sda_sync_q[1]);

    // The stop pulse is the commit point; the link clock may stand still afterwards.
    always_comb
    begin
        busy_d = busy_q;
        if (start_w)
        begin
            busy_d = 1'b1;
        end
        else if (stop_w)
        begin
            busy_d = 1'b0;
        end
        stop_d = stop_w & busy_q;
    end

    // Registers of the monitor.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            sda_prev_q <= 1'b1;
            busy_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            sda_prev_q <= sda_prev_d;
            busy_q <= busy_d;
            stop_q <= stop_d;
        end
    end

    assign twi.stop_pulse = stop_q;
    assign twi.busy = busy_q;

endmodule

// File: dv/mmt_host_model.sv
// Host controller model that frames transactions on the two-wire management bus lines.
`timescale 1ns/1ps
module mmt_host_model
(
    input wire logic clk_in,
    input wire logic go_in,
    output logic scl_out,
    output logic sda_out,
    output logic done_out
);
    // ****************************************************************
    // Bus framing
    // ****************************************************************
    // Half of the 160 ns link clock, in 20 ns system cycles.
    localparam int HALF = 4;

    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Both lines are pulled up, so between frames they rest high and the link clock stands still.
    // One frame: start, three data bits, stop, then a handshake with the requester.
    // Data only moves while the link clock is low, so no false start or stop is made.
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        done_out = 1'b0;
        forever
        begin
            @(posedge clk_in iff go_in);
            sda_out <= 1'b0;
            hold(HALF);
            repeat (3)
            begin
                scl_out <= 1'b0;
                sda_out <= ~sda_out;
                hold(HALF);
                scl_out <= 1'b1;
                hold(HALF);
            end
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            hold(HALF);
            scl_out <= 1'b1;
            hold(HALF);
            sda_out <= 1'b1;
            hold(HALF);
            done_out <= 1'b1;
            @(posedge clk_in iff !go_in);
            done_out <= 1'b0;
        end
    end
endmodule

// File: dv/mmt_core_tb.sv
// Self-checking testbench of the module management timing block.
`timescale 1ns/1ps
module mmt_core_tb;
    // ****************************************************************
    // Stimulus, design and host model
    // ****************************************************************
    // Start-up count is shortened so that the run stays brief.
    localparam int INIT = 200;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic rst_n = 1'b1;
    logic lp = 1'b0;
    logic sel_n = 1'b0;
    logic los = 1'b0;
    logic txf = 1'b0;
    logic [5:0] oth = 6'h00;
    logic rd = 1'b0;
    logic mw = 1'b0;
    logic [7:0] md = 8'h00;
    logic pw = 1'b0;
    logic pd = 1'b0;
    logic go = 1'b0;
    logic scl, sda, done, int_n, dnr, lpo, bus, rdy;
    logic [7:0] flg, msk, rv, mk;
    logic [15:0] lfsr = 16'hEA83;
    int fail_count = 0;
    int checks_done = 0;
    int n;

    // Free-running 50 MHz clock.
    always #10 clk_in = ~clk_in;

    mmt_core #(.FLAG_W(8), .INIT_CYCLES(INIT)) dut
    (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .module_reset_n_in(rst_n),
        .low_power_request_in(lp), .module_select_n_in(sel_n), .scl_in(scl), .sda_in(sda),
        .rx_los_in(los), .tx_fault_in(txf), .other_cond_in(oth), .flag_read_in(rd),
        .mask_wr_in(mw), .mask_wr_data_in(md), .pdown_wr_in(pw), .pdown_wr_data_in(pd),
        .interrupt_out_n(int_n), .data_not_ready_out(dnr), .flag_out(flg), .mask_out(msk),
        .low_power_out(lpo), .bus_respond_out(bus), .ready_out(rdy)
    );

    mmt_host_model u_host
    (
        .clk_in(clk_in), .go_in(go), .scl_out(scl), .sda_out(sda), .done_out(done)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction

    // Interrupt is low while any latched flag is left unmasked.
    function automatic logic int_exp(input logic [7:0] f, input logic [7:0] m);
        int_exp = ~|(f & ~m);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    task automatic wait_ready();
        n = 0;
        while (dnr !== 1'b0 && n < INIT + 60)
        begin
            cyc(1);
            n++;
        end
    endtask

    // One bus transaction; the pulses land mid-frame so they fall between start and stop.
    task automatic xact(input logic r, input logic w, input logic [7:0] d, input logic p, input logic pv);
        go <= 1'b1;
        cyc(6);
        rd <= r;
        mw <= w;
        md <= d;
        pw <= p;
        pd <= pv;
        cyc(1);
        rd <= 1'b0;
        mw <= 1'b0;
        pw <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200)
        begin
            cyc(1);
            n++;
        end
        // A frame that never ends is a failure in its own right.
        if (done !== 1'b1)
            fail_count++;
        go <= 1'b0;
        cyc(10);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    // Start-up, flag and mask traffic, power control, select and module reset in turn.
    initial
    begin
        cyc(12);
        chk({int_n, dnr, lpo, bus, rdy}, 8'h18);
        chk(flg | msk, 8'h00);
        sys_rst_in <= 1'b0;
        wait_ready();
        chk(n <= INIT + 6, 1'b1);
        chk({int_n, rdy}, 8'h01);
        chk(rdy, 1'b1);
        cyc(6);
        chk(bus, 1'b1);
        xact(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        chk(int_n, 1'b1);
        // Random condition sets under random masks, then mask removal and clear on read.
        repeat (6)
        begin
            lfsr = lfsr_next(lfsr);
            rv = (lfsr[7:0] == 8'h00) ? 8'h80 : lfsr[7:0];
            mk = lfsr[15:8];
            xact(1'b0, 1'b1, mk, 1'b0, 1'b0);
            chk(msk, mk);
            los <= rv[0];
            txf <= rv[1];
            oth <= rv[7:2];
            cyc(10);
            chk(flg, rv);
            chk(int_n, int_exp(rv, mk));
            xact(1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
            chk(int_n, int_exp(rv, 8'h00));
            los <= 1'b0;
            txf <= 1'b0;
            oth <= 6'h00;
            xact(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
            chk(flg, 8'h00);
            chk(int_n, 1'b1);
        end
        lp <= 1'b1;
        cyc(6);
        chk(lpo, 1'b1);
        lp <= 1'b0;
        cyc(6);
        chk(lpo, 1'b0);
        xact(1'b0, 1'b0, 8'h00, 1'b1, 1'b1);
        chk(lpo, 1'b1);
        xact(1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        chk({lpo, rdy}, 8'h01);
        sel_n <= 1'b1;
        cyc(6);
        chk(bus, 1'b0);
        sel_n <= 1'b0;
        cyc(6);
        chk(bus, 1'b1);
        // A short low on the reset pin is ignored; a long one restarts the module.
        rst_n <= 1'b0;
        cyc(50);
        rst_n <= 1'b1;
        cyc(10);
        chk(dnr, 1'b0);
        rst_n <= 1'b0;
        cyc(110);
        chk(dnr, 1'b1);
        rst_n <= 1'b1;
        wait_ready();
        chk(n <= INIT + 10, 1'b1);
        chk(int_n, 1'b0);
        tally_and_finish();
    end

    // Watchdog well beyond the expected two thousand or fewer cycles of the sequence.
    initial
    begin
        cyc(20000);
        fail_count++;
        tally_and_finish();
    end
endmodule
